// ### ptit_pkg.sv
// Constants shared by the periodic tap interrupt timer and its divider chain.
// Assumes a single 50 MHz system clock and an AHB-Lite register bus.
package ptit_pkg;

   localparam int          CHAIN_STAGES  = 15;
   localparam int          CNT_W         = 22;
   localparam int          TAP_SEL_W     = 3;

   typedef logic [4:0] ptit_tap_t;

   // Extra prescale stages placed ahead of the chain when the upper range is picked.
   localparam ptit_tap_t   RANGE_STAGES  = 5'h07;

   // Log2 of the divide ratio for tap codes 7 down to 0 in the lower range.
   localparam logic [7:0][4:0] TAP_LOG_LO = {5'h03, 5'h04, 5'h05, 5'h06,
                                             5'h07, 5'h0b, 5'h0d, 5'h0f};

   localparam logic [11:0] CTRL_OFFSET   = 12'h000;
   localparam int          FLAG_BIT      = 7;
   localparam int          TAP_LSB       = 4;
   localparam int          ACK_BIT       = 3;
   localparam int          IRQ_EN_BIT    = 2;
   localparam int          RUN_BIT       = 1;
   localparam logic [7:0]  CTRL_RESET    = 8'h00;

   localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
   localparam logic        HRESP_OKAY    = 1'b0;

endpackage

// ### ptit_div_if.sv
// Link between the control block and the divider chain of the periodic timer.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface ptit_div_if;
   import ptit_pkg::*;

   logic      run;
   logic      tick;
   ptit_tap_t tap_idx;
   logic      rollover;

   modport ctrl (output run, output tick, output tap_idx, input rollover);
   modport div  (input run, input tick, input tap_idx, output rollover);
endinterface

// ### ptit_divider.sv
// Binary divider chain with a selectable rollover tap.
// Assumes tick is a one-cycle pulse per source clock edge on the system clock.
`timescale 1ns/1ps
module ptit_divider
#(
   parameter int W = ptit_pkg::CNT_W
)
(
   input  wire logic sys_clk_i,
   input  wire logic rst_n_i,
   ptit_div_if.div   dif
);
   import ptit_pkg::*;

   typedef struct packed {
      logic [W-1:0] cnt;
      logic         roll;
   } ptit_div_st_t;

   ptit_div_st_t q;
   ptit_div_st_t d;
   logic [W-1:0] nxt;
   ptit_tap_t    bit_idx;

   always_comb
   begin
      d       = q;
      d.roll  = 1'b0;
      nxt     = q.cnt + {{(W-1){1'b0}}, 1'b1};
      bit_idx = dif.tap_idx - 5'h01;
      if (!dif.run)
      begin
         d.cnt = '0;
      end
      else if (dif.tick)
      begin
         d.cnt = nxt;
         // The half-weight bit rising gives half a period first, then whole periods.
         if (nxt[bit_idx] && !q.cnt[bit_idx])
         begin
            d.roll = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign dif.rollover = q.roll;

   property p_hold_zero;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      !dif.run |=> (q.cnt == '0);
   endproperty
   a_hold_zero: assert property (p_hold_zero)
      else $error("Divider not held at zero while stopped.");

   property p_roll_cause;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      q.roll |-> $past(dif.tick && dif.run);
   endproperty
   a_roll_cause: assert property (p_roll_cause)
      else $error("Rollover without a counted source edge.");

   property p_first_half;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (q.roll && dif.tap_idx == 5'h03) |-> (q.cnt[2:0] == 3'h4);
   endproperty
   a_first_half: assert property (p_first_half)
      else $error("Rollover off the half-weight boundary.");
endmodule

// ### ptit_timer.sv
// Periodic tap interrupt timer: control register on AHB-Lite, source clock
// selection and synchronisation, rollover flag and interrupt request.
// Assumes oscillator clocks arrive as asynchronous pins much slower than sys_clk_i.
//
// Contract
// - Divider chain has fifteen binary stages; eight are selectable as tap.
// - Source is external oscillator when enabled, else internal oscillator.
// - Chain is held at zero while run is clear; counts once set.
// - Overflow at the selected tap sets the read-only rollover flag.
// - Flag set with interrupt enable set raises the CPU request.
// - First rollover at half the period, then exactly every period.
// - Lower range: ratios 32768, 8192, 2048, 128, 64, 32, 16, 8.
// - Upper range: ratios 4194304 down to 1024 as tabulated.
// - Writing one to acknowledge clears the flag; acknowledge reads zero.
// - Writing zero to acknowledge changes nothing.
// - In wait mode the divider runs but the register is unreachable.
// - In stop mode the divider runs only if oscillator is kept alive.
// - Otherwise divider idles in stop; register unreachable in stop.
// - Interrupt enable is read/write, cleared by reset, gates the request.
// - Run bit is read/write, reset clears it; toggling reinitialises chain.
// - Clearing run leaves the rollover flag unchanged.
//
// Our own choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
module ptit_timer
(
   input  wire logic        sys_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic      [31:0] hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   input  wire logic        external_osc_clock_i,
   input  wire logic        internal_osc_clock_i,
   input  wire logic        external_osc_on_i,
   input  wire logic        osc_kept_in_stop_i,
   input  wire logic        tap_range_select_i,
   input  wire logic        wait_mode_i,
   input  wire logic        stop_mode_i,
   output logic             irq_o
);
   import ptit_pkg::*;

   typedef struct packed {
      logic [2:0]           ext_sync;
      logic [2:0]           int_sync;
      logic                 run;
      logic                 en;
      logic                 flag;
      logic [TAP_SEL_W-1:0] tap;
      logic                 wr_pend;
      logic [31:0]          hrdata;
      logic                 hready;
      logic                 hresp;
      logic                 irq;
   } ptit_st_t;

   ptit_st_t   q;
   ptit_st_t   d;
   ptit_div_if dif ();

   logic       ext_rise;
   logic       int_rise;
   logic       src_rise;
   logic       src_alive;
   logic       bus_ok;
   logic       ap;
   logic       hit;
   logic       ack_wr;
   logic [7:0] ctrl_rd;

   // Only the second and third stages are compared; the first is left alone.
   assign ext_rise  = q.ext_sync[1] & ~q.ext_sync[2];
   assign int_rise  = q.int_sync[1] & ~q.int_sync[2];
   assign src_rise  = external_osc_on_i ? ext_rise : int_rise;
   assign src_alive = !stop_mode_i || osc_kept_in_stop_i;
   assign bus_ok    = !wait_mode_i && !stop_mode_i;
   assign ap        = hsel_i && hready_i && htrans_i[1];
   assign hit       = (haddr_i[11:2] == CTRL_OFFSET[11:2]);
   assign ack_wr    = q.wr_pend && hwdata_i[ACK_BIT];

   // The acknowledge position always reads back as zero.
   assign ctrl_rd   = {q.flag, q.tap, 1'b0, q.en, q.run, 1'b0};

   assign dif.run     = q.run;
   assign dif.tick    = src_rise && src_alive;
   // The upper range places seven extra stages ahead of the same taps.
   assign dif.tap_idx = TAP_LOG_LO[q.tap]
                        + (tap_range_select_i ? RANGE_STAGES : 5'h00);

   ptit_divider #(
      .W (CNT_W)
   ) u_divider (
      .sys_clk_i (sys_clk_i),
      .rst_n_i   (rst_n_i),
      .dif       (dif)
   );

   always_comb
   begin
      d          = q;
      d.ext_sync = {q.ext_sync[1:0], external_osc_clock_i};
      d.int_sync = {q.int_sync[1:0], internal_osc_clock_i};
      d.hready   = 1'b1;
      d.hresp    = HRESP_OKAY;
      d.wr_pend  = ap && hwrite_i && hit && bus_ok;
      if (ap && !hwrite_i)
      begin
         if (hit && bus_ok)
         begin
            d.hrdata = {24'h000000, ctrl_rd};
         end
         else
         begin
            d.hrdata = 32'h00000000;
         end
      end
      if (q.wr_pend)
      begin
         d.run = hwdata_i[RUN_BIT];
         d.en  = hwdata_i[IRQ_EN_BIT];
         d.tap = hwdata_i[TAP_LSB +: TAP_SEL_W];
      end
      if (ack_wr)
      begin
         d.flag = 1'b0;
      end
      if (dif.rollover)
      begin
         d.flag = 1'b1;
      end
      d.irq = d.flag && d.en;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         q        <= '0;
         q.run    <= CTRL_RESET[RUN_BIT];
         q.en     <= CTRL_RESET[IRQ_EN_BIT];
         q.flag   <= CTRL_RESET[FLAG_BIT];
         q.tap    <= CTRL_RESET[TAP_LSB +: TAP_SEL_W];
         q.hready <= 1'b1;
         q.hresp  <= HRESP_OKAY;
      end
      else
      begin
         q <= d;
      end
   end

   assign hrdata_o    = q.hrdata;
   assign hreadyout_o = q.hready;
   assign hresp_o     = q.hresp;
   assign irq_o       = q.irq;

   property p_flag_set;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      dif.rollover |=> q.flag;
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("Rollover did not set the flag.");

   property p_set_wins;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (dif.rollover && ack_wr) |=> q.flag;
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("Acknowledge lost a simultaneous rollover.");

   property p_ack_clear;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (ack_wr && !dif.rollover) |=> !q.flag;
   endproperty
   a_ack_clear: assert property (p_ack_clear)
      else $error("Acknowledge write did not clear the flag.");

   property p_ack_zero;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (q.wr_pend && !hwdata_i[ACK_BIT] && q.flag) |=> q.flag;
   endproperty
   a_ack_zero: assert property (p_ack_zero)
      else $error("Writing zero to acknowledge cleared the flag.");

   property p_irq_rise;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (dif.rollover && q.en && !q.wr_pend) |=> irq_o;
   endproperty
   a_irq_rise: assert property (p_irq_rise)
      else $error("Enabled rollover raised no request.");

   property p_irq_gated;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (!q.en && !q.wr_pend) |=> !irq_o;
   endproperty
   a_irq_gated: assert property (p_irq_gated)
      else $error("Request raised while disabled.");

   property p_wait_block;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (ap && hwrite_i && wait_mode_i) |=> !q.wr_pend ##1 $stable(q.run);
   endproperty
   a_wait_block: assert property (p_wait_block)
      else $error("Register written during wait mode.");

   property p_stop_idle;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (stop_mode_i && !osc_kept_in_stop_i) |-> !dif.tick;
   endproperty
   a_stop_idle: assert property (p_stop_idle)
      else $error("Divider ticked in stop without oscillator.");

   property p_run_keeps_flag;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (q.wr_pend && !hwdata_i[RUN_BIT] && !hwdata_i[ACK_BIT] && q.flag) |=> q.flag;
   endproperty
   a_run_keeps_flag: assert property (p_run_keeps_flag)
      else $error("Stopping the timer changed the flag.");

   property p_ack_reads_zero;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      $past(ap && !hwrite_i) |-> !hrdata_o[ACK_BIT];
   endproperty
   a_ack_reads_zero: assert property (p_ack_reads_zero)
      else $error("Acknowledge bit read back as one.");

   property p_wr_run;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      q.wr_pend |=> (q.run == $past(hwdata_i[RUN_BIT]));
   endproperty
   a_wr_run: assert property (p_wr_run)
      else $error("Run bit did not take the written value.");

   property p_wr_en;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      q.wr_pend |=> (q.en == $past(hwdata_i[IRQ_EN_BIT]));
   endproperty
   a_wr_en: assert property (p_wr_en)
      else $error("Interrupt enable did not take the written value.");

   property p_wr_tap;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      q.wr_pend |=> (q.tap == $past(hwdata_i[TAP_LSB +: TAP_SEL_W]));
   endproperty
   a_wr_tap: assert property (p_wr_tap)
      else $error("Tap select did not take the written value.");

   property p_ctrl_hold;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      !q.wr_pend |=> $stable({q.run, q.en, q.tap});
   endproperty
   a_ctrl_hold: assert property (p_ctrl_hold)
      else $error("Control fields changed without a write.");

   property p_flag_hold;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (!dif.rollover && !ack_wr) |=> $stable(q.flag);
   endproperty
   a_flag_hold: assert property (p_flag_hold)
      else $error("Flag changed with no rollover and no acknowledge.");

   property p_irq_clear;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (ack_wr && !dif.rollover) |=> !irq_o;
   endproperty
   a_irq_clear: assert property (p_irq_clear)
      else $error("Acknowledge did not withdraw the request.");

   property p_read_fields;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (ap && !hwrite_i && hit && bus_ok) |=> (hrdata_o[FLAG_BIT] == $past(q.flag))
         && (hrdata_o[IRQ_EN_BIT] == $past(q.en)) && (hrdata_o[RUN_BIT] == $past(q.run));
   endproperty
   a_read_fields: assert property (p_read_fields)
      else $error("Read data does not show the control state.");

   property p_read_refused;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (ap && !hwrite_i && !bus_ok) |=> (hrdata_o == 32'h00000000);
   endproperty
   a_read_refused: assert property (p_read_refused)
      else $error("Register readable in a low-power mode.");

   property p_src_ext;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (external_osc_on_i && !ext_rise) |-> !dif.tick;
   endproperty
   a_src_ext: assert property (p_src_ext)
      else $error("Tick without an external oscillator edge.");

   property p_src_int;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (!external_osc_on_i && !int_rise) |-> !dif.tick;
   endproperty
   a_src_int: assert property (p_src_int)
      else $error("Tick without an internal oscillator edge.");

   property p_wait_counts;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (wait_mode_i && !stop_mode_i && src_rise) |-> dif.tick;
   endproperty
   a_wait_counts: assert property (p_wait_counts)
      else $error("Divider missed a source edge in wait mode.");

   property p_stop_kept;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (stop_mode_i && osc_kept_in_stop_i && src_rise) |-> dif.tick;
   endproperty
   a_stop_kept: assert property (p_stop_kept)
      else $error("Divider missed a source edge in stop with oscillator kept.");

   property p_stop_block;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (ap && hwrite_i && stop_mode_i) |=> !q.wr_pend;
   endproperty
   a_stop_block: assert property (p_stop_block)
      else $error("Register written during stop mode.");

   property p_tap_lo_min;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (q.tap == 3'h7 && !tap_range_select_i) |-> (dif.tap_idx == 5'h03);
   endproperty
   a_tap_lo_min: assert property (p_tap_lo_min)
      else $error("Lower range code 7 does not divide by 8.");

   property p_tap_lo_mid;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (q.tap == 3'h3 && !tap_range_select_i) |-> (dif.tap_idx == 5'h07);
   endproperty
   a_tap_lo_mid: assert property (p_tap_lo_mid)
      else $error("Lower range code 3 does not divide by 128.");

   property p_tap_hi_min;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (q.tap == 3'h7 && tap_range_select_i) |-> (dif.tap_idx == 5'h0a);
   endproperty
   a_tap_hi_min: assert property (p_tap_hi_min)
      else $error("Upper range code 7 does not divide by 1024.");
endmodule

// ### ptit_tb.sv
// Self-checking bench for the periodic tap interrupt timer, with a behavioural model.
// Assumes the timer's bus port alone on AHB-Lite, with hready fed back from hreadyout.
`timescale 1ns/1ps
module tb;
   import ptit_pkg::*;
`define CHK(nm, ex, sn) begin comparisons++; if ((sn) !== (ex)) begin err_total++; \
   $display("ERROR %s expected %0h seen %0h", nm, ex, sn); end end

   logic        sys_clk_i = 1'b0;
   logic        rst_n_i   = 1'b0;
   logic        hsel      = 1'b0;
   logic [31:0] haddr     = 32'h0;
   logic [1:0]  htrans    = 2'h0;
   logic        hwrite    = 1'b0;
   logic [31:0] hwdata    = 32'h0;
   logic [31:0] hrdata;
   logic        hready;
   logic        hresp;
   logic        ext_clk   = 1'b0;
   logic        int_clk   = 1'b0;
   logic        ext_on    = 1'b0;
   logic        kept      = 1'b0;
   logic        rng       = 1'b0;
   logic        wait_m    = 1'b0;
   logic        stop_m    = 1'b0;
   logic        irq;
   int          err_total = 0;
   int          comparisons = 0;
   integer      seed      = 32'hf6dd;
   int          ratio_lo[8] = '{32768, 8192, 2048, 128, 64, 32, 16, 8};
   int          ratio_hi[8] = '{4194304, 1048576, 262144, 16384, 8192, 4096, 2048, 1024};
   int          edge_cnt;
   int          due_q[$];
   logic        exp_flag  = 1'b0;
   logic [7:0]  ctrl      = 8'h00;
   logic [31:0] rd;

   always #10 sys_clk_i = ~sys_clk_i;

   ptit_timer dut_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
      .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
      .external_osc_clock_i(ext_clk), .internal_osc_clock_i(int_clk),
      .external_osc_on_i(ext_on), .osc_kept_in_stop_i(kept), .tap_range_select_i(rng),
      .wait_mode_i(wait_m), .stop_mode_i(stop_m), .irq_o(irq));

   task automatic print_verdict;
      $display("Errors %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic wait_ready;
      int k;
      k = 0;
      do
      begin
         @(posedge sys_clk_i);
         k++;
      end
      while (hready !== 1'b1 && k < 50);
      if (k >= 50)
      begin
         err_total++;
         print_verdict();
      end
   endtask

   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready();
      rd = hrdata;
      // One idle cycle lets the written state reach the outputs before any check.
      @(posedge sys_clk_i);
   endtask

   function automatic logic [31:0] model_read;
      return {24'h0, exp_flag, ctrl[6:4], 1'b0, ctrl[2:1], 1'b0};
   endfunction

   // Each source edge is a slow square wave; the unselected pin toggles at random.
   task automatic edges(input int n);
      for (int e = 0; e < n; e++)
      begin
         for (int h = 1; h >= 0; h--)
         begin
            if (ext_on) {ext_clk, int_clk} <= {h[0], 1'($random(seed))};
            else        {int_clk, ext_clk} <= {h[0], 1'($random(seed))};
            repeat (5) @(posedge sys_clk_i);
         end
         if (ctrl[1] && !(stop_m && !kept)) edge_cnt++;
         if (due_q.size() > 0 && edge_cnt == due_q[0])
         begin
            void'(due_q.pop_front());
            exp_flag = 1'b1;
         end
      end
      {ext_clk, int_clk} <= 2'b00;
      repeat (10) @(posedge sys_clk_i);
   endtask

   task automatic start(input logic [7:0] c, input int n);
      ctrl = c;
      ahb(1'b1, 32'h0, {24'h0, c});
      edge_cnt = 0;
      due_q = {n / 2, n / 2 + n};
   endtask

   initial
   begin
      int tap;
      int n;
      repeat (10) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      ahb(1'b0, 32'h0, 32'h0);
      `CHK("ctrl_reset", model_read(), rd)
      ahb(1'b1, 32'h4, $random(seed));
      ahb(1'b0, 32'h4, 32'h0);
      `CHK("unmapped", 32'h0, rd)
      ahb(1'b0, 32'h0, 32'h0);
      `CHK("ctrl_unmapped", model_read(), rd)
      for (int i = 0; i < 6; i++)
      begin
         tap = (i == 5) ? 7 : 3 + i;
         rng <= (i == 5);
         ext_on <= i[0];
         kept <= 1'b1;
         n = (i == 5) ? ratio_hi[tap] : ratio_lo[tap];
         start({1'b0, 3'(tap), 4'b0110}, n);
         edges(n / 2 - 1);
         `CHK("irq_early", 1'b0, irq)
         edges(1);
         `CHK("irq_first", 1'b1, irq)
         ahb(1'b1, 32'h0, {24'h0, ctrl});
         `CHK("irq_ack0", 1'b1, irq)
         ahb(1'b1, 32'h0, {24'h0, ctrl | 8'h08});
         exp_flag = 1'b0;
         `CHK("irq_ack1", 1'b0, irq)
         wait_m <= (i % 3 == 1);
         stop_m <= (i % 3 == 2);
         edges(n - 1);
         if (i % 3 != 0) ahb(1'b1, 32'h0, 32'h0);
         ahb(1'b0, 32'h0, 32'h0);
         `CHK("ctrl_lowpow", (i % 3 == 0) ? model_read() : 32'h0, rd)
         `CHK("irq_mid", 1'b0, irq)
         edges(1);
         `CHK("irq_period", 1'b1, irq)
         wait_m <= 1'b0;
         stop_m <= 1'b0;
         ahb(1'b0, 32'h0, 32'h0);
         `CHK("ctrl_flag", model_read(), rd)
         ctrl[2:1] = 2'b00;
         ahb(1'b1, 32'h0, {24'h0, ctrl});
         `CHK("irq_masked", 1'b0, irq)
         ahb(1'b0, 32'h0, 32'h0);
         `CHK("ctrl_stopped", model_read(), rd)
         ahb(1'b1, 32'h0, {24'h0, ctrl | 8'h08});
         exp_flag = 1'b0;
      end
      rng <= 1'b0;
      kept <= 1'b0;
      start(8'h76, 8);
      stop_m <= 1'b1;
      edges(8);
      `CHK("irq_stopped", 1'b0, irq)
      stop_m <= 1'b0;
      edges(4);
      `CHK("irq_after_stop", 1'b1, irq)
      print_verdict();
   end
endmodule
